// [osc_ctrl_pkg.sv]
// Shared constants, register map and the pin claim type for the oscillator control block
package osc_ctrl_pkg;

	// Clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int LF_NOMINAL_HZ = 80_000;
	localparam int LF_HALF_CYCLES = CLK_HZ / (2 * LF_NOMINAL_HZ);
	localparam int LF_TRIM_STEP = 2;
	localparam int LF_SETTLE_OSC_CYCLES = 16;
	localparam int LF_CNT_W = 8;
	localparam int SETTLE_CNT_W = 5;

	// Bus geometry
	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;
	localparam int AXI_STRB_W = AXI_DATA_W / 8;
	localparam int REG_W = 8;
	localparam int ADDR_SHIFT = 2;

	// Register indices; byte address is four times the index
	localparam logic [AXI_ADDR_W-1:0] LOWFREQ_OSC_CONTROL_IDX = 12'h0e3;
	localparam logic [AXI_ADDR_W-1:0] EXTERNAL_OSC_CONTROL_IDX = 12'h0b1;
	localparam logic [AXI_ADDR_W-1:0] INT_STATUS_IDX = 12'h0f0;
	localparam logic [AXI_ADDR_W-1:0] INT_MASK_IDX = 12'h0f1;

	// Field positions of lowfreq_osc_control
	localparam int LF_EN_BIT = 7;
	localparam int LF_RDY_BIT = 6;
	localparam int LF_TRIM_HI = 5;
	localparam int LF_TRIM_LO = 2;
	localparam int LF_DIV_HI = 1;
	localparam int LF_DIV_LO = 0;

	// Field positions of external_osc_control
	localparam int XTAL_VALID_BIT = 7;
	localparam int EXT_MODE_HI = 6;
	localparam int EXT_MODE_LO = 4;
	localparam int EXT_FREQ_HI = 2;
	localparam int EXT_FREQ_LO = 0;

	// Interrupt status bit positions
	localparam int INT_W = 2;
	localparam int INT_LF_READY = 0;
	localparam int INT_XTAL_VALID = 1;

	// Reset values
	localparam logic [3:0] LF_TRIM_RST = 4'h8;
	localparam logic [1:0] LF_DIV_RST = 2'h0;
	localparam logic [2:0] EXT_MODE_RST = 3'h0;
	localparam logic [2:0] EXT_FREQ_RST = 3'h0;

	// Divider select encodings
	localparam logic [1:0] LF_DIV8 = 2'h0;
	localparam logic [1:0] LF_DIV4 = 2'h1;
	localparam logic [1:0] LF_DIV2 = 2'h2;
	localparam logic [1:0] LF_DIV1 = 2'h3;

	// External mode encodings
	localparam logic [2:0] EXT_CMOS = 3'h2;
	localparam logic [2:0] EXT_CMOS_DIV2 = 3'h3;
	localparam logic [2:0] EXT_RC = 3'h4;
	localparam logic [2:0] EXT_CAP = 3'h5;
	localparam logic [2:0] EXT_XTAL = 3'h6;
	localparam logic [2:0] EXT_XTAL_DIV2 = 3'h7;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Pin claims of the external oscillator
	typedef struct packed {
		logic claimIn;
		logic claimOut;
		logic driveEnable;
	} ext_pins_s;

endpackage

// [lf_osc_core.sv]
// Low-frequency oscillator model with trim, output divider and settling counter
`timescale 1ns/100ps
`default_nettype none
module lf_osc_core
	import osc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [3:0] trim,
	input wire logic [1:0] divSel,
	input wire logic restart,
	output logic clkOut,
	output logic settled
);
	typedef struct packed {
		logic [LF_CNT_W-1:0] halfCnt;
		logic raw;
		logic [2:0] divCnt;
		logic [SETTLE_CNT_W-1:0] settleCnt;
		logic done;
		logic out;
		logic settled;
	} lf_state_s;

	lf_state_s st_reg;
	lf_state_s st_next;
	logic [LF_CNT_W-1:0] halfLen;
	logic rise;

	always_comb begin
		st_next = st_reg;
		halfLen = LF_CNT_W'(LF_HALF_CYCLES) + LF_CNT_W'(int'(trim) * LF_TRIM_STEP);
		rise = 1'b0;
		st_next.settled = 1'b0;
		if (!enable) begin
			st_next.halfCnt = '0;
			st_next.raw = 1'b0;
			st_next.divCnt = '0;
			st_next.out = 1'b0;
		end else begin
			if (st_reg.halfCnt >= halfLen - LF_CNT_W'(1)) begin
				st_next.halfCnt = '0;
				st_next.raw = ~st_reg.raw;
				rise = ~st_reg.raw;
			end else begin
				st_next.halfCnt = st_reg.halfCnt + LF_CNT_W'(1);
			end
			if (rise) begin
				st_next.divCnt = st_reg.divCnt + 3'h1;
			end
			case (divSel)
				LF_DIV1: st_next.out = st_next.raw;
				LF_DIV2: st_next.out = st_next.divCnt[0];
				LF_DIV4: st_next.out = st_next.divCnt[1];
				default: st_next.out = st_next.divCnt[2];
			endcase
		end
		if (restart) begin
			st_next.settleCnt = '0;
			st_next.done = 1'b0;
		end else if (rise && !st_reg.done) begin
			if (st_reg.settleCnt == SETTLE_CNT_W'(LF_SETTLE_OSC_CYCLES - 1)) begin
				st_next.done = 1'b1;
				st_next.settled = 1'b1;
			end else begin
				st_next.settleCnt = st_reg.settleCnt + SETTLE_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign clkOut = st_reg.out;
	assign settled = st_reg.settled;
endmodule
`default_nettype wire

// [ext_osc_core.sv]
// External oscillator pin claims, clock input and crystal valid detection
`timescale 1ns/100ps
`default_nettype none
module ext_osc_core
	import osc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] mode,
	input wire logic ampOkPin,
	input wire logic extClkPin,
	output ext_pins_s pins,
	output logic extClkOut,
	output logic crystalValid
);
	typedef struct packed {
		logic [1:0] ampSync;
		logic [2:0] clkSync;
		logic half;
		ext_pins_s pins;
		logic clkOut;
		logic valid;
	} ext_state_s;

	ext_state_s st_reg;
	ext_state_s st_next;
	logic isXtal;
	logic isOn;

	always_comb begin
		st_next = st_reg;
		st_next.ampSync = {st_reg.ampSync[0], ampOkPin};
		st_next.clkSync = {st_reg.clkSync[1:0], extClkPin};
		isXtal = (mode == EXT_XTAL) || (mode == EXT_XTAL_DIV2);
		isOn = mode[2] || mode[1];
		st_next.pins.claimIn = isXtal;
		// other modes except off claim only the output pin
		st_next.pins.claimOut = isOn;
		st_next.pins.driveEnable = isOn && (mode != EXT_CMOS) && (mode != EXT_CMOS_DIV2);
		st_next.valid = isXtal && st_reg.ampSync[1];
		if (!isOn) begin
			st_next.half = 1'b0;
			st_next.clkOut = 1'b0;
		end else begin
			if (st_reg.clkSync[1] && !st_reg.clkSync[2]) begin
				st_next.half = ~st_reg.half;
			end
			if (mode[0] && mode != EXT_CAP) begin
				st_next.clkOut = st_next.half;
			end else begin
				st_next.clkOut = st_reg.clkSync[1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pins = st_reg.pins;
	assign extClkOut = st_reg.clkOut;
	assign crystalValid = st_reg.valid;
endmodule
`default_nettype wire

// [osc_ctrl_top.sv]
// Oscillator control registers behind an AXI4-Lite slave
// What this block does
// - Enable bit 7 runs or stops LF oscillator
// - Bit 6 reads one once LF stabilized
// - Ready clears only on reset or divider change
// - Trim bits 5:2, zero fastest, ones slowest
// - Divider bits 1:0 select 8,4,2,1; reset 00
// - Crystal mode claims both crystal pins
// - CMOS, RC, capacitor modes claim output pin
// - Mode field decodes off, CMOS, RC, C, crystal
// - Crystal valid bit 7 meaningful in crystal modes
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl_top
	import osc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic crystalAmpOk,
	input wire logic extClkPin,
	output logic lfClkOut,
	output logic [3:0] lfTrimOut,
	output logic extClkOut,
	output logic [2:0] extModeOut,
	output logic [2:0] extFreqOut,
	output ext_pins_s extPins,
	output logic irq
);
	typedef struct packed {
		logic awReady;
		logic wReady;
		logic awHeld;
		logic [AXI_ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [AXI_DATA_W-1:0] wData;
		logic [AXI_STRB_W-1:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [AXI_DATA_W-1:0] rData;
		logic [1:0] rResp;
		logic lfEnable;
		logic lfReady;
		logic [3:0] lfTrim;
		logic [1:0] lfDiv;
		logic lfRestart;
		logic [2:0] extMode;
		logic [2:0] extFreq;
		logic [INT_W-1:0] intStatus;
		logic [INT_W-1:0] intMask;
		logic irq;
		logic xtalPrev;
	} top_state_s;

	top_state_s st_reg;
	top_state_s st_next;

	logic lfClkInt;
	logic lfSettled;
	logic extClkInt;
	logic xtalValid;
	ext_pins_s pinsInt;

	logic [REG_W-1:0] lfRegVal;
	logic [REG_W-1:0] extRegVal;
	logic [INT_W-1:0] events;
	logic [INT_W-1:0] w1c;
	logic writeFire;
	logic [REG_W-1:0] wByte;
	logic wLane;
	logic readHit;
	logic writeHit;
	logic [REG_W-1:0] readVal;

	// Byte address to register index
	function automatic logic [AXI_ADDR_W-1:0] regIndex(input logic [AXI_ADDR_W-1:0] addr);
		regIndex = addr >> ADDR_SHIFT;
	endfunction

	// Whether an index is a mapped register
	function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] idx);
		isMapped = (idx == LOWFREQ_OSC_CONTROL_IDX) || (idx == EXTERNAL_OSC_CONTROL_IDX) ||
			(idx == INT_STATUS_IDX) || (idx == INT_MASK_IDX);
	endfunction

	lf_osc_core lfCore (
		.clk(clk),
		.rst(rst),
		.enable(st_reg.lfEnable),
		.trim(st_reg.lfTrim),
		.divSel(st_reg.lfDiv),
		.restart(st_reg.lfRestart),
		.clkOut(lfClkInt),
		.settled(lfSettled)
	);

	ext_osc_core extCore (
		.clk(clk),
		.rst(rst),
		.mode(st_reg.extMode),
		.ampOkPin(crystalAmpOk),
		.extClkPin(extClkPin),
		.pins(pinsInt),
		.extClkOut(extClkInt),
		.crystalValid(xtalValid)
	);

	always_comb begin
		st_next = st_reg;
		st_next.lfRestart = 1'b0;
		st_next.xtalPrev = xtalValid;

		// Register images as software reads them
		lfRegVal = '0;
		lfRegVal[LF_EN_BIT] = st_reg.lfEnable;
		lfRegVal[LF_RDY_BIT] = st_reg.lfReady;
		lfRegVal[LF_TRIM_HI:LF_TRIM_LO] = st_reg.lfTrim;
		lfRegVal[LF_DIV_HI:LF_DIV_LO] = st_reg.lfDiv;
		extRegVal = '0;
		extRegVal[XTAL_VALID_BIT] = xtalValid;
		extRegVal[EXT_MODE_HI:EXT_MODE_LO] = st_reg.extMode;
		extRegVal[EXT_FREQ_HI:EXT_FREQ_LO] = st_reg.extFreq;

		// Write address and data taken in either order
		if (s_axi_awvalid && st_reg.awReady) begin
			st_next.awHeld = 1'b1;
			st_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wReady) begin
			st_next.wHeld = 1'b1;
			st_next.wData = s_axi_wdata;
			st_next.wStrb = s_axi_wstrb;
		end
		if (st_reg.bValid && s_axi_bready) begin
			st_next.bValid = 1'b0;
		end

		writeFire = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
		writeHit = isMapped(regIndex(st_reg.awAddr));
		wByte = st_reg.wData[REG_W-1:0];
		wLane = st_reg.wStrb[0];
		w1c = '0;

		if (writeFire) begin
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
			st_next.bValid = 1'b1;
			st_next.bResp = writeHit ? RESP_OKAY : RESP_DECERR;
			if (wLane) begin
				case (regIndex(st_reg.awAddr))
					LOWFREQ_OSC_CONTROL_IDX: begin
						st_next.lfEnable = wByte[LF_EN_BIT];
						st_next.lfTrim = wByte[LF_TRIM_HI:LF_TRIM_LO];
						st_next.lfDiv = wByte[LF_DIV_HI:LF_DIV_LO];
						if (wByte[LF_DIV_HI:LF_DIV_LO] != st_reg.lfDiv) begin
							st_next.lfReady = 1'b0;
							st_next.lfRestart = 1'b1;
						end
						if (wByte[LF_EN_BIT] && !st_reg.lfEnable) begin
							st_next.lfRestart = 1'b1;
						end
					end
					EXTERNAL_OSC_CONTROL_IDX: begin
						st_next.extMode = wByte[EXT_MODE_HI:EXT_MODE_LO];
						st_next.extFreq = wByte[EXT_FREQ_HI:EXT_FREQ_LO];
					end
					INT_STATUS_IDX: begin
						w1c = wByte[INT_W-1:0];
					end
					INT_MASK_IDX: begin
						st_next.intMask = wByte[INT_W-1:0];
					end
					default: begin
						w1c = '0;
					end
				endcase
			end
		end

		// ready sets on settling, winning over a clear
		if (lfSettled) begin
			st_next.lfReady = 1'b1;
		end

		// Sticky events, set wins over write-one-to-clear
		events = '0;
		events[INT_LF_READY] = lfSettled && !st_reg.lfReady;
		events[INT_XTAL_VALID] = xtalValid && !st_reg.xtalPrev;
		st_next.intStatus = (st_reg.intStatus & ~w1c) | events;
		st_next.irq = |(st_next.intStatus & st_next.intMask);

		// Read channel
		readHit = isMapped(regIndex(s_axi_araddr));
		case (regIndex(s_axi_araddr))
			LOWFREQ_OSC_CONTROL_IDX: readVal = lfRegVal;
			EXTERNAL_OSC_CONTROL_IDX: readVal = extRegVal;
			INT_STATUS_IDX: readVal = REG_W'(st_reg.intStatus);
			INT_MASK_IDX: readVal = REG_W'(st_reg.intMask);
			default: readVal = '0;
		endcase
		if (st_reg.rValid && s_axi_rready) begin
			st_next.rValid = 1'b0;
		end
		if (s_axi_arvalid && st_reg.arReady) begin
			st_next.rValid = 1'b1;
			st_next.rData = AXI_DATA_W'(readVal);
			st_next.rResp = readHit ? RESP_OKAY : RESP_DECERR;
		end

		// One write and one read outstanding at most
		st_next.awReady = !st_next.awHeld && !st_next.bValid;
		st_next.wReady = !st_next.wHeld && !st_next.bValid;
		st_next.arReady = !st_next.rValid;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.lfTrim <= LF_TRIM_RST;
			st_reg.lfDiv <= LF_DIV_RST;
			st_reg.extMode <= EXT_MODE_RST;
			st_reg.extFreq <= EXT_FREQ_RST;
			st_reg.bResp <= RESP_OKAY;
			st_reg.rResp <= RESP_OKAY;
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_axi_awready = st_reg.awReady;
	assign s_axi_wready = st_reg.wReady;
	assign s_axi_bvalid = st_reg.bValid;
	assign s_axi_bresp = st_reg.bResp;
	assign s_axi_arready = st_reg.arReady;
	assign s_axi_rvalid = st_reg.rValid;
	assign s_axi_rdata = st_reg.rData;
	assign s_axi_rresp = st_reg.rResp;
	assign lfClkOut = lfClkInt;
	assign lfTrimOut = st_reg.lfTrim;
	assign extClkOut = extClkInt;
	assign extModeOut = st_reg.extMode;
	assign extFreqOut = st_reg.extFreq;
	assign extPins = pinsInt;
	assign irq = st_reg.irq;
endmodule
`default_nettype wire

// [ext_source_model.sv]
// External clock source and crystal amplitude detector model
`timescale 1ns/100ps
`default_nettype none
module ext_source_model (
	input wire logic [2:0] mode,
	output logic ampOk,
	output logic clkPin
);
	initial begin
		ampOk = 1'b0;
		clkPin = 1'b0;
		// digital clock, edges kept off clk edges
		#25;
		forever #350 clkPin = !clkPin;
	end
	// crystal amplitude good after a while
	always @(mode) begin
		if (mode[2:1] != 2'b11) ampOk = 1'b0;
		else ampOk <= #2030 1'b1;
	end
endmodule
`default_nettype wire

// [osc_ctrl_top_sva.sv]
// Assertion checker for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl_top_sva
	import osc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic extClkOut,
	input wire logic [2:0] extModeOut,
	input wire ext_pins_s extPins
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("bresp not held");
	a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid after handshake");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("rdata not held");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during rvalid");
	a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed up");
	a_claim_in: assert property ($stable(extModeOut)[*3] |->
		extPins.claimIn == (extModeOut[2:1] == 2'b11)) else $error("input pin claim");
	a_claim_out: assert property ($stable(extModeOut)[*3] |->
		extPins.claimOut == (extModeOut[2:1] != 2'b00)) else $error("output pin claim");
	a_drive_mode: assert property ($stable(extModeOut)[*3] |->
		extPins.driveEnable == extModeOut[2]) else $error("drive enable");
	a_clk_off: assert property ($stable(extModeOut)[*4] |->
		extModeOut[2:1] != 2'b00 || !extClkOut) else $error("ext clock while off");
endmodule
bind osc_ctrl_top osc_ctrl_top_sva chk_u (.clk(clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .extClkOut(extClkOut), .extModeOut(extModeOut),
	.extPins(extPins));
`default_nettype wire

// [test_lf_osc_and_ext_osc_control.sv]
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module test_lf_osc_and_ext_osc_control
	import osc_ctrl_pkg::*;
;
	logic clk = 0, rst = 1, awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
	logic [11:0] awAddr = 0, arAddr = 0;
	logic [31:0] wData = 0, rData;
	logic [3:0] wStrb = 0, trimOut;
	logic awReady, wReady, bValid, arReady, rValid, lfClk, extClk, irq, ampOk, pinClk, prevExt;
	logic [1:0] bResp, rResp;
	logic [2:0] modeOut, freqOut;
	ext_pins_s pins;
	int miscompares = 0, checksDone = 0, cycles = 0, n;
	localparam logic [11:0] LF = LOWFREQ_OSC_CONTROL_IDX;
	localparam logic [11:0] EXT = EXTERNAL_OSC_CONTROL_IDX;
	osc_ctrl_top dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.crystalAmpOk(ampOk), .extClkPin(pinClk), .lfClkOut(lfClk), .lfTrimOut(trimOut),
		.extClkOut(extClk), .extModeOut(modeOut), .extFreqOut(freqOut), .extPins(pins),
		.irq(irq));
	ext_source_model src_u (.mode(modeOut), .ampOk(ampOk), .clkPin(pinClk));
	always #50 clk = ~clk;
	task automatic stop_test;
		if (miscompares == 0 && checksDone > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checksDone++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic done;
		done = 0;
		awAddr <= a << 2;
		wData <= {24'h0, d};
		wStrb <= s;
		awValid <= 1;
		wValid <= 1;
		bReady <= 1;
		while (!done) begin
			@(posedge clk);
			if (awValid && awReady) awValid <= 0;
			if (wValid && wReady) wValid <= 0;
			if (bValid && bReady) begin
				check("bresp", er, bResp);
				done = 1;
			end
		end
		bReady <= 0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic done;
		done = 0;
		arAddr <= a << 2;
		arValid <= 1;
		rReady <= 1;
		while (!done) begin
			@(posedge clk);
			if (arValid && arReady) arValid <= 0;
			if (rValid && rReady) begin
				check("rdata", e, rData);
				check("rresp", er, rResp);
				done = 1;
			end
		end
		rReady <= 0;
		@(posedge clk);
	endtask
	task automatic edges(input int len, input int e);
		int c;
		logic p;
		c = 0;
		repeat (200) @(posedge clk);
		p = lfClk;
		repeat (len) begin
			@(posedge clk);
			if (lfClk && !p) c++;
			p = lfClk;
		end
		check("lfClk edges", e, c);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(LF, 32'h20, RESP_OKAY);
		rd(EXT, 32'h0, RESP_OKAY);
		rd(12'h010, 32'h0, RESP_DECERR);
		wr(12'h010, 8'hff, 4'hf, RESP_DECERR);
		wr(INT_MASK_IDX, 8'h01, 4'h1, RESP_OKAY);
		wr(LF, 8'h83, 4'h1, RESP_OKAY);
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		check("settle time", 1, n >= 1800 && n < 2100);
		rd(LF, 32'hc3, RESP_OKAY);
		edges(1240, 10);
		wr(LF, 8'hbf, 4'h1, RESP_OKAY);
		rd(LF, 32'hff, RESP_OKAY);
		check("lfTrimOut", 4'hf, trimOut);
		edges(1840, 10);
		wr(LF, 8'h3f, 4'h1, RESP_OKAY);
		edges(400, 0);
		check("lfClkOut", 0, lfClk);
		rd(LF, 32'h7f, RESP_OKAY);
		wr(LF, 8'h7e, 4'h1, RESP_OKAY);
		rd(LF, 32'h3e, RESP_OKAY);
		wr(LF, 8'h83, 4'h0, RESP_OKAY);
		rd(LF, 32'h3e, RESP_OKAY);
		rd(INT_STATUS_IDX, 32'h1, RESP_OKAY);
		check("irq", 1, irq);
		wr(INT_STATUS_IDX, 8'h01, 4'h1, RESP_OKAY);
		rd(INT_STATUS_IDX, 32'h0, RESP_OKAY);
		check("irq", 0, irq);
		for (logic [3:0] m = 0; m < 8; m++) begin
			// mode and frequency chosen before use
			wr(EXT, {1'b1, m[2:0], 4'hd}, 4'h1, RESP_OKAY);
			repeat (12) @(posedge clk);
			// Rising edges of extClkOut over four source periods
			n = 0;
			prevExt = extClk;
			repeat (28) begin
				@(posedge clk);
				if (extClk && !prevExt) n++;
				prevExt = extClk;
			end
			check("extClk", m[2:1] == 2'b00 ? 0 : (m[1:0] == 2'b11 ? 2 : 4), n);
			rd(EXT, {24'h0, m[2:1] == 2'b11, m[2:0], 4'h5}, RESP_OKAY);
			check("extPins", {m[2:1] == 2'b11, m[2:1] != 2'b00, m[2]}, pins);
			check("extModeOut", m[2:0], modeOut);
			check("extFreqOut", 3'h5, freqOut);
		end
		rd(INT_STATUS_IDX, 32'h2, RESP_OKAY);
		check("irq", 0, irq);
		wr(INT_MASK_IDX, 8'h03, 4'h1, RESP_OKAY);
		check("irq", 1, irq);
		wr(INT_STATUS_IDX, 8'h02, 4'h1, RESP_OKAY);
		check("irq", 0, irq);
		stop_test();
	end
endmodule
`default_nettype wire
